// ===== common/csr_map.svh
/*
 register offsets, field positions and reset values of the clock status
 readback bank. assumes byte-wide registers on a plain address/data port.
*/
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
`define CSR_ADDR_W 10
`define CSR_OFF_CLK_LOCK 10'h22C
`define CSR_OFF_HOLD_CAL 10'h22D
`define CSR_OFF_MON_SEL 10'h230
`define CSR_BIT_SYN_REF 7
`define CSR_BIT_SYN_FB 6
`define CSR_BIT_XO 5
`define CSR_BIT_TEST_REF 4
`define CSR_BIT_REF_B 3
`define CSR_BIT_REF_A 2
`define CSR_BIT_SYN_LOCK 1
`define CSR_BIT_CLN_LOCK 0
`define CSR_BIT_HOLDOVER 3
`define CSR_BIT_AUTO_SEL 2
`define CSR_BIT_VCO_CAL 0
`define CSR_MON_SEL_W 6
`define CSR_MON_SEL_RST 6'h00
`endif

// ===== common/csr_pkg.sv
/*
 types shared by the clock status readback bank.
 assumes csr_map.svh is on the include path.
*/
`include "csr_map.svh"
package csr_pkg;
   typedef logic [7:0] csr_byte_type;
   typedef logic [`CSR_ADDR_W-1:0] csr_addr_type;
   typedef enum logic [5:0] {
      CSR_MON_GND = 6'h00,
      CSR_MON_BOTH_LOCK = 6'h01,
      CSR_MON_CLN_LOCK = 6'h02,
      CSR_MON_SYN_LOCK = 6'h03,
      CSR_MON_REFS_LOST = 6'h04
   } csr_mon_code_type;
endpackage : csr_pkg

// ===== rtl/csr_mon_mux.sv
/*
 status monitor selector: maps a 6-bit code to one status level.
 assumes status inputs synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_mon_mux (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // selection
   input wire logic [5:0] sel_in,
   // status levels
   input wire logic cln_lock_in,
   input wire logic syn_lock_in,
   input wire logic ref_a_ok_in,
   input wire logic ref_b_ok_in,
   // monitor pin
   output logic mon_out
);
   import csr_pkg::*;
   logic mon_ff;
   logic nxt_mon;

   always_comb begin
      case (sel_in)
         CSR_MON_GND: nxt_mon = 1'b0;
         CSR_MON_BOTH_LOCK: nxt_mon = cln_lock_in & syn_lock_in;
         CSR_MON_CLN_LOCK: nxt_mon = cln_lock_in;
         CSR_MON_SYN_LOCK: nxt_mon = syn_lock_in;
         CSR_MON_REFS_LOST: nxt_mon = ~ref_a_ok_in & ~ref_b_ok_in;
         // codes past 4 are not implemented here; drive ground
         default: nxt_mon = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         mon_ff <= 1'b0;
      end else begin
         mon_ff <= nxt_mon;
      end
   end

   assign mon_out = mon_ff;

   mon_refs_lost_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      sel_in == 6'h04 && !ref_a_ok_in && !ref_b_ok_in |=> mon_out)
      else $error("monitor missed both references lost");
   mon_gnd_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      sel_in == 6'h00 |=> !mon_out)
      else $error("monitor not grounded on code 0");
endmodule : csr_mon_mux
`default_nettype wire

// ===== rtl/csr_status_bank.sv
/*
 clock status readback bank: two read-only live status bytes and one
 read/write monitor selector, reached over a plain byte register port.
 assumes status flags come synchronous to clk_sys_in from the detectors.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"
// Contract
// - bit 7 reg0 shows synthesis reference present
// - bit 6 reg0 shows synthesis feedback present
// - bits 5..2 show oscillator, test, B, A
// - bits 1,0 show synthesis, cleanup lock
// - reg1 bit 3 shows holdover active
// - reg1 bit 2 shows auto-selected reference
// - reg1 bit 0 shows calibration running
// - monitor register bits 5..0 select condition
// - codes 0..3: ground, both, cleanup, synthesis
// - code 4 flags both references missing
module csr_status_bank (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // register port
   input wire csr_pkg::csr_addr_type reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire csr_pkg::csr_byte_type reg_wdata_in,
   output csr_pkg::csr_byte_type reg_rdata_out,
   output logic reg_rvalid_out,
   // clock presence flags
   input wire logic syn_ref_ok_in,
   input wire logic syn_fb_ok_in,
   input wire logic xo_ok_in,
   input wire logic test_ref_ok_in,
   input wire logic ref_b_ok_in,
   input wire logic ref_a_ok_in,
   // loop and control state
   input wire logic syn_lock_in,
   input wire logic cln_lock_in,
   input wire logic holdover_in,
   input wire logic auto_ref_b_in,
   input wire logic vco_cal_busy_in,
   // monitor pin and selector
   output logic mon_out,
   output logic [5:0] mon_sel_out
);
   import csr_pkg::*;

   logic [`CSR_MON_SEL_W-1:0] mon_sel_ff;
   logic [`CSR_MON_SEL_W-1:0] nxt_mon_sel;
   csr_byte_type rdata_ff;
   csr_byte_type nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;
   csr_byte_type clk_lock_byte;
   csr_byte_type hold_cal_byte;

   // live status bytes, assembled each cycle so reads are never stale
   always_comb begin
      clk_lock_byte = 8'h00;
      clk_lock_byte[`CSR_BIT_SYN_REF] = syn_ref_ok_in;
      clk_lock_byte[`CSR_BIT_SYN_FB] = syn_fb_ok_in;
      clk_lock_byte[`CSR_BIT_XO] = xo_ok_in;
      clk_lock_byte[`CSR_BIT_TEST_REF] = test_ref_ok_in;
      clk_lock_byte[`CSR_BIT_REF_B] = ref_b_ok_in;
      clk_lock_byte[`CSR_BIT_REF_A] = ref_a_ok_in;
      clk_lock_byte[`CSR_BIT_SYN_LOCK] = syn_lock_in;
      clk_lock_byte[`CSR_BIT_CLN_LOCK] = cln_lock_in;
      hold_cal_byte = 8'h00; // reserved bits stay zero
      hold_cal_byte[`CSR_BIT_HOLDOVER] = holdover_in;
      // only meaningful in auto select mode; passed through regardless
      hold_cal_byte[`CSR_BIT_AUTO_SEL] = auto_ref_b_in;
      hold_cal_byte[`CSR_BIT_VCO_CAL] = vco_cal_busy_in;
   end

   // selector register; writes to the readback bytes fall through
   always_comb begin
      nxt_mon_sel = mon_sel_ff;
      if (reg_wr_in && reg_addr_in == `CSR_OFF_MON_SEL) begin
         nxt_mon_sel = reg_wdata_in[`CSR_MON_SEL_W-1:0];
      end
   end

   // read path: one cycle latency, unmapped reads return zero
   always_comb begin
      nxt_rvalid = reg_rd_in;
      nxt_rdata = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `CSR_OFF_CLK_LOCK: nxt_rdata = clk_lock_byte;
            `CSR_OFF_HOLD_CAL: nxt_rdata = hold_cal_byte;
            `CSR_OFF_MON_SEL: nxt_rdata = {2'b00, mon_sel_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         mon_sel_ff <= `CSR_MON_SEL_RST;
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         mon_sel_ff <= nxt_mon_sel;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign reg_rvalid_out = rvalid_ff;
   assign mon_sel_out = mon_sel_ff;

   csr_mon_mux u_mon_mux (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .sel_in(mon_sel_ff),
      .cln_lock_in(cln_lock_in),
      .syn_lock_in(syn_lock_in),
      .ref_a_ok_in(ref_a_ok_in),
      .ref_b_ok_in(ref_b_ok_in),
      .mon_out(mon_out)
   );

   sequence rd_status0_s;
      reg_rd_in && reg_addr_in == `CSR_OFF_CLK_LOCK;
   endsequence
   sequence rd_status1_s;
      reg_rd_in && reg_addr_in == `CSR_OFF_HOLD_CAL;
   endsequence
   sequence rd_select_s;
      reg_rd_in && reg_addr_in == `CSR_OFF_MON_SEL;
   endsequence
   sequence wr_select_s;
      reg_wr_in && reg_addr_in == `CSR_OFF_MON_SEL;
   endsequence
   // code 1 and both loops locked, with the selector still on code 1 a cycle later
   sequence both_locked_held_s;
      mon_sel_out == 6'h01 && cln_lock_in && syn_lock_in && !reg_wr_in
      ##1 mon_sel_out == 6'h01;
   endsequence

   property syn_ref_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status0_s |=> reg_rvalid_out && reg_rdata_out[7] == $past(syn_ref_ok_in);
   endproperty
   rd_syn_ref_a: assert property (syn_ref_p)
      else $error("synthesis reference bit wrong");

   property syn_fb_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status0_s |=> reg_rdata_out[6] == $past(syn_fb_ok_in);
   endproperty
   rd_syn_fb_a: assert property (syn_fb_p)
      else $error("synthesis feedback bit wrong");

   property clk_flags_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status0_s |=> reg_rdata_out[5:2] ==
         $past({xo_ok_in, test_ref_ok_in, ref_b_ok_in, ref_a_ok_in});
   endproperty
   rd_clk_flags_a: assert property (clk_flags_p)
      else $error("clock presence bits wrong");

   property lock_bits_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status0_s |=> reg_rdata_out[1:0] == $past({syn_lock_in, cln_lock_in});
   endproperty
   rd_lock_bits_a: assert property (lock_bits_p)
      else $error("lock bits wrong");

   property holdover_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status1_s |=> reg_rdata_out[3] == $past(holdover_in);
   endproperty
   rd_holdover_a: assert property (holdover_p)
      else $error("holdover bit wrong");

   property auto_sel_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status1_s |=> reg_rdata_out[2] == $past(auto_ref_b_in);
   endproperty
   rd_auto_sel_a: assert property (auto_sel_p)
      else $error("selected reference bit wrong");

   property vco_cal_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status1_s |=> reg_rdata_out[0] == $past(vco_cal_busy_in);
   endproperty
   rd_vco_cal_a: assert property (vco_cal_p)
      else $error("calibration bit wrong");

   property reserved_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_status1_s |=> reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[1];
   endproperty
   rd_reserved_a: assert property (reserved_p)
      else $error("reserved bits not zero");

   // every read strobe gets exactly one answer one cycle later
   property rd_answer_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      reg_rd_in |=> reg_rvalid_out;
   endproperty
   rd_answer_a: assert property (rd_answer_p)
      else $error("read strobe not answered");

   // idle bus shows zero, so a stale byte is never mistaken for live status
   property rd_idle_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00;
   endproperty
   rd_idle_a: assert property (rd_idle_p)
      else $error("read answer without a strobe");

   // read and write in one cycle return the old selector
   property rd_select_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      rd_select_s |=> reg_rdata_out == {2'b00, $past(mon_sel_out)};
   endproperty
   rd_select_a: assert property (rd_select_p)
      else $error("selector readback wrong");

   property sel_write_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      wr_select_s |=> mon_sel_out == $past(reg_wdata_in[5:0]);
   endproperty
   sel_write_a: assert property (sel_write_p)
      else $error("selector write lost");

   // writes to the readback bytes must not leak into the selector
   property sel_hold_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      !(reg_wr_in && reg_addr_in == `CSR_OFF_MON_SEL) |=> $stable(mon_sel_out);
   endproperty
   sel_hold_a: assert property (sel_hold_p)
      else $error("selector changed without a write");

   property mon_both_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      both_locked_held_s |-> mon_out;
   endproperty
   mon_both_a: assert property (mon_both_p)
      else $error("monitor missed both loops locked");

   property mon_cleanup_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      mon_sel_out == CSR_MON_CLN_LOCK |=> mon_out == $past(cln_lock_in);
   endproperty
   mon_cleanup_a: assert property (mon_cleanup_p)
      else $error("monitor does not follow cleanup lock");

   property mon_synth_p;
      @(posedge clk_sys_in) disable iff (srst_in)
      mon_sel_out == CSR_MON_SYN_LOCK |=> mon_out == $past(syn_lock_in);
   endproperty
   mon_synth_a: assert property (mon_synth_p)
      else $error("monitor does not follow synthesis lock");
endmodule : csr_status_bank
`default_nettype wire

// ===== verification/csr_status_bank_tb_top.sv
/*
 self-checking bench for the clock status readback bank.
 assumes csr_pkg and csr_map.svh are compiled and on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module csr_status_bank_tb_top;
   import csr_pkg::*;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   csr_addr_type addr = 10'h000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   csr_byte_type wdata = 8'h00;
   csr_byte_type rdata;
   logic rvalid;
   // 10 cal, 9 auto b, 8 holdover, 7..0 in readback bit order
   logic [10:0] st = 11'h000;
   logic mon;
   logic [5:0] mon_sel;
   int mismatches = 0;
   int comparisons = 0;
   csr_status_bank dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .syn_ref_ok_in(st[7]), .syn_fb_ok_in(st[6]), .xo_ok_in(st[5]),
      .test_ref_ok_in(st[4]), .ref_b_ok_in(st[3]), .ref_a_ok_in(st[2]),
      .syn_lock_in(st[1]), .cln_lock_in(st[0]), .holdover_in(st[8]),
      .auto_ref_b_in(st[9]), .vco_cal_busy_in(st[10]),
      .mon_out(mon), .mon_sel_out(mon_sel));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // answer is registered, so it is looked at one negedge after the strobe
   task automatic reg_read(input csr_addr_type a, input csr_byte_type e);
      @(negedge clk_sys_in);
      addr = a;
      rd = 1'b1;
      @(negedge clk_sys_in);
      rd = 1'b0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
      @(negedge clk_sys_in);
      `CHK(rvalid, 1'b0)
      `CHK(rdata, 8'h00)
   endtask : reg_read
   task automatic reg_write(input csr_addr_type a, input csr_byte_type d);
      @(negedge clk_sys_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys_in);
      wr = 1'b0;
   endtask : reg_write
   function automatic logic exp_mon(input int c, input logic [3:0] v);
      case (c)
         1: return v[0] & v[1];
         2: return v[0];
         3: return v[1];
         4: return ~v[2] & ~v[3];
         default: return 1'b0;
      endcase
   endfunction : exp_mon
   // walking one plus all-set and all-clear, so a swapped bit shows up
   task automatic test_status_bits;
      for (int i = 0; i < 13; i++) begin
         st = (i < 11) ? 11'(1 << i) : ((i == 11) ? 11'h7ff : 11'h000);
         reg_read(`CSR_OFF_CLK_LOCK, st[7:0]);
         reg_read(`CSR_OFF_HOLD_CAL, {4'h0, st[8], st[9], 1'b0, st[10]});
      end
   endtask : test_status_bits
   task automatic test_read_only;
      st = 11'h555;
      reg_write(`CSR_OFF_CLK_LOCK, 8'hff);
      reg_write(`CSR_OFF_HOLD_CAL, 8'hff);
      `CHK(mon_sel, 6'h00)
      reg_read(`CSR_OFF_CLK_LOCK, 8'h55);
      reg_read(`CSR_OFF_HOLD_CAL, 8'h09);
      reg_write(`CSR_OFF_MON_SEL, 8'hc5);
      reg_read(`CSR_OFF_MON_SEL, 8'h05);
      reg_read(10'h231, 8'h00);
   endtask : test_read_only
   task automatic test_monitor;
      for (int c = 0; c < 6; c++) begin
         reg_write(`CSR_OFF_MON_SEL, 8'(c));
         `CHK(mon_sel, 6'(c))
         for (int v = 0; v < 16; v++) begin
            st = 11'(v);
            @(negedge clk_sys_in);
            `CHK(mon, exp_mon(c, st[3:0]))
         end
      end
   endtask : test_monitor
   initial begin
      repeat (10) @(negedge clk_sys_in);
      srst_in = 1'b0;
      `CHK(mon_sel, 6'h00)
      test_status_bits();
      test_read_only();
      test_monitor();
      end_of_test();
   end
   // whole run is a few hundred cycles; this only cuts a hang short
   initial begin
      #100us;
      mismatches++;
      end_of_test();
   end
endmodule : csr_status_bank_tb_top
`default_nettype wire
